// ### mmd_pkg.sv
// Address map constants and shared types for the memory map decoder.
// Assumes a 32-bit byte address space seen by all bus masters.
package mmd_pkg;

	// ***************************************
	// Region bases and sizes
	// ***************************************
	localparam logic [31:0] MMD_ROM_BASE = 32'h0000_0000;
	localparam logic [31:0] MMD_ROM_SIZE = 32'h0001_0000;
	localparam logic [31:0] MMD_CODE_BASE = 32'h000b_0000;
	localparam logic [31:0] MMD_CODE_SIZE = 32'h0006_8000;
	localparam logic [31:0] MMD_DATA_BASE = 32'h0011_8000;
	localparam logic [31:0] MMD_DATA_SIZE = 32'h0001_0000;
	localparam logic [31:0] MMD_ALIAS_BASE = 32'h2000_0000;
	localparam logic [31:0] MMD_SBB_BASE = 32'h2200_0000;
	localparam logic [31:0] MMD_SBB_SIZE = 32'h0020_0000;
	localparam logic [31:0] MMD_REG_BASE = 32'h4000_0000;
	localparam logic [31:0] MMD_REG_SIZE = 32'h0010_0000;
	localparam logic [31:0] MMD_ECREG_BASE = 32'h4000_0000;
	localparam logic [31:0] MMD_ECREG_SIZE = 32'h0001_0000;
	localparam logic [31:0] MMD_GPIO_BASE = 32'h4008_0000;
	localparam logic [31:0] MMD_GPIO_SIZE = 32'h0001_0000;
	localparam logic [31:0] MMD_CRYPTO_BASE = 32'h4010_0000;
	localparam logic [31:0] MMD_CRYPTO_SIZE = 32'h0000_4000;
	localparam logic [31:0] MMD_RBB_BASE = 32'h4200_0000;
	localparam logic [31:0] MMD_RBB_SIZE = 32'h0200_0000;

	// ***************************************
	// Types
	// ***************************************
	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_ROM,
		TGT_CODE,
		TGT_DATA,
		TGT_REGS,
		TGT_CRYPTO
	} mmd_tgt_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACC,
		ST_MOD,
		ST_WB,
		ST_DONE
	} mmd_fsm_t;

	typedef struct packed {
		mmd_fsm_t st;
		mmd_tgt_t tgt;
		logic [31:0] t_addr;
		logic [31:0] t_wdata;
		logic [31:0] m_rdata;
		logic t_req;
		logic t_write;
		logic t_fetch;
		logic m_ready;
		logic m_done;
		logic m_fault;
		logic bb;
		logic wr;
		logic bb_val;
		logic [4:0] bit_idx;
	} mmd_state_t;

endpackage : mmd_pkg

// ### mmd_decoder.sv
// Memory map decoder: one master port in, one translated target port out.
// Assumes the target answers each t_req with a single-cycle t_ack and data.
// Summary of operation
// RL1 - A 64KB boot ROM is decoded from address zero.
// RL2 - After system reset the first fetches at address zero go to the boot ROM.
// RL3 - A 416KB code SRAM and a 64KB data SRAM are decoded, 480KB in total.
// RL4 - Both SRAMs accept fetches and data accesses; requests are serialised.
// RL5 - The window at 20000000h reaches the data SRAM at 118000h, same size.
// RL6 - Each SRAM bit-band word maps one SRAM bit into bit 0, upper bits zero.
// RL7 - The register bit-band region is a 32-to-1 alias of the register space.
// RL8 - Only device and pin registers are reachable through register bit-band.
// RL9 - A bit-band write is done as read, bit modify, then write back.
// RL10 - Software should avoid bit-band writes to registers with read effects.
// RL11 - Bit-band access by any master other than the processor faults.
// RL12 - SRAM bit-band starts at 22000000h, register bit-band at 42000000h.
// RL13 - The cryptographic RAM window spans 40100000h to 40103fffh.
`timescale 1ns/1ps
module mmd_decoder
	import mmd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Master request
	input wire logic m_req,
	input wire logic [31:0] m_addr,
	input wire logic m_write,
	input wire logic [31:0] m_wdata,
	input wire logic m_is_cpu,
	input wire logic m_fetch,
	// Master answer
	output logic m_ready,
	output logic m_done,
	output logic m_fault,
	output logic [31:0] m_rdata,
	// Target request
	output logic t_req,
	output mmd_pkg::mmd_tgt_t t_sel,
	output logic [31:0] t_addr,
	output logic t_write,
	output logic [31:0] t_wdata,
	output logic t_fetch,
	// Target answer
	input wire logic t_ack,
	input wire logic [31:0] t_rdata
);
	import mmd_pkg::*;

	// ***************************************
	// State
	// ***************************************
	localparam mmd_state_t MMD_RST = '{
		st: ST_IDLE,
		tgt: TGT_NONE,
		m_ready: 1'b1,
		default: '0
	};

	mmd_state_t r_reg;
	mmd_state_t r_next;

	function automatic logic in_rng(
		input logic [31:0] a,
		input logic [31:0] base,
		input logic [31:0] size
	);
		logic [31:0] d;
		d = a - base;
		return d < size;
	endfunction : in_rng

	// ***************************************
	// Decode and sequencing
	// ***************************************
	always_comb
	begin
		mmd_tgt_t tg;
		logic [31:0] pa;
		logic [31:0] off;
		logic [31:0] mw;
		logic bb;
		logic [4:0] bi;
		logic flt;
		tg = TGT_NONE;
		pa = m_addr;
		off = '0;
		mw = t_rdata;
		bb = 1'b0;
		bi = '0;
		flt = 1'b0;
		r_next = r_reg;

		// RL1 RL2 boot ROM at zero
		if (in_rng(m_addr, MMD_ROM_BASE, MMD_ROM_SIZE))
		begin
			tg = TGT_ROM;
		end
		// RL3 code SRAM
		else if (in_rng(m_addr, MMD_CODE_BASE, MMD_CODE_SIZE))
		begin
			tg = TGT_CODE;
		end
		// RL3 data SRAM
		else if (in_rng(m_addr, MMD_DATA_BASE, MMD_DATA_SIZE))
		begin
			tg = TGT_DATA;
		end
		// RL5 alias window
		else if (in_rng(m_addr, MMD_ALIAS_BASE, MMD_DATA_SIZE))
		begin
			tg = TGT_DATA;
			pa = MMD_DATA_BASE + (m_addr - MMD_ALIAS_BASE);
		end
		// RL12 SRAM bit-band word to bit
		else if (in_rng(m_addr, MMD_SBB_BASE, MMD_SBB_SIZE))
		begin
			off = m_addr - MMD_SBB_BASE;
			tg = TGT_DATA;
			bb = 1'b1;
			bi = off[6:2];
			pa = MMD_DATA_BASE + {5'h00, off[31:7], 2'h0};
		end
		else if (in_rng(m_addr, MMD_REG_BASE, MMD_REG_SIZE))
		begin
			tg = TGT_REGS;
		end
		// RL13 crypto window
		else if (in_rng(m_addr, MMD_CRYPTO_BASE, MMD_CRYPTO_SIZE))
		begin
			tg = TGT_CRYPTO;
		end
		// RL7 register bit-band alias
		else if (in_rng(m_addr, MMD_RBB_BASE, MMD_RBB_SIZE))
		begin
			off = m_addr - MMD_RBB_BASE;
			bb = 1'b1;
			bi = off[6:2];
			pa = MMD_REG_BASE + {5'h00, off[31:7], 2'h0};
			// RL8 only device and pin registers
			if (in_rng(pa, MMD_ECREG_BASE, MMD_ECREG_SIZE)
				|| in_rng(pa, MMD_GPIO_BASE, MMD_GPIO_SIZE))
			begin
				tg = TGT_REGS;
			end
		end

		// RL11 bit-band is processor only
		flt = (tg == TGT_NONE) || (tg == TGT_ROM && m_write) || (bb && !m_is_cpu);

		unique case (r_reg.st)
			ST_IDLE:
			begin
				if (m_req)
				begin
					r_next.m_ready = 1'b0;
					r_next.wr = m_write;
					if (flt)
					begin
						r_next.m_fault = 1'b1;
						r_next.m_rdata = '0;
						r_next.m_done = 1'b1;
						r_next.st = ST_DONE;
					end
					else
					begin
						r_next.m_fault = 1'b0;
						r_next.t_req = 1'b1;
						r_next.tgt = tg;
						r_next.t_addr = pa;
						// RL9 bit-band write starts with a read
						r_next.t_write = m_write && !bb;
						r_next.t_wdata = m_wdata;
						// RL4 fetch flag passes to the SRAM
						r_next.t_fetch = m_fetch;
						r_next.bb = bb;
						r_next.bit_idx = bi;
						r_next.bb_val = m_wdata[0];
						r_next.st = ST_ACC;
					end
				end
			end
			ST_ACC:
			begin
				if (t_ack)
				begin
					r_next.t_req = 1'b0;
					if (r_reg.bb && r_reg.wr)
					begin
						// RL9 modify the selected bit
						mw[r_reg.bit_idx] = r_reg.bb_val;
						r_next.t_wdata = mw;
						r_next.st = ST_MOD;
					end
					else
					begin
						r_next.t_write = 1'b0;
						// RL6 bit-band read returns bit 0 only
						r_next.m_rdata = r_reg.bb ? {31'h0, t_rdata[r_reg.bit_idx]} : t_rdata;
						r_next.m_done = 1'b1;
						r_next.st = ST_DONE;
					end
				end
			end
			ST_MOD:
			begin
				// RL9 write back to the same word
				r_next.t_req = 1'b1;
				r_next.t_write = 1'b1;
				r_next.st = ST_WB;
			end
			ST_WB:
			begin
				if (t_ack)
				begin
					r_next.t_req = 1'b0;
					r_next.t_write = 1'b0;
					r_next.m_rdata = '0;
					r_next.m_done = 1'b1;
					r_next.st = ST_DONE;
				end
			end
			ST_DONE:
			begin
				r_next.m_done = 1'b0;
				r_next.m_ready = 1'b1;
				r_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			r_reg <= MMD_RST;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// ***************************************
	// Outputs
	// ***************************************
	assign m_ready = r_reg.m_ready;
	assign m_done = r_reg.m_done;
	assign m_fault = r_reg.m_fault;
	assign m_rdata = r_reg.m_rdata;
	assign t_req = r_reg.t_req;
	assign t_sel = r_reg.tgt;
	assign t_addr = r_reg.t_addr;
	assign t_write = r_reg.t_write;
	assign t_wdata = r_reg.t_wdata;
	assign t_fetch = r_reg.t_fetch;

	// ***************************************
	// Assertions
	// ***************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	logic take;
	assign take = m_req && m_ready;

	property p_rom_map;
		take && m_addr < MMD_ROM_SIZE && !m_write
		|=> t_req && t_sel == TGT_ROM && t_addr == $past(m_addr);
	endproperty
	a_rom_map: assert property (p_rom_map) else $error("ROM not decoded"); // RL1

	property p_boot_fetch;
		take && m_fetch && m_addr == MMD_ROM_BASE
		|=> !m_fault ##0 t_sel == TGT_ROM ##0 t_fetch;
	endproperty
	a_boot_fetch: assert property (p_boot_fetch) else $error("Boot fetch misrouted"); // RL2

	property p_sram_map;
		take && in_rng(m_addr, MMD_CODE_BASE, MMD_CODE_SIZE)
		|=> t_sel == TGT_CODE && t_addr == $past(m_addr);
	endproperty
	a_sram_map: assert property (p_sram_map) else $error("Code SRAM not decoded"); // RL3

	property p_fetch_pass;
		take && in_rng(m_addr, MMD_DATA_BASE, MMD_DATA_SIZE)
		|=> t_sel == TGT_DATA && t_fetch == $past(m_fetch) && !m_fault;
	endproperty
	a_fetch_pass: assert property (p_fetch_pass) else $error("Data SRAM access lost"); // RL4

	property p_alias;
		take && in_rng(m_addr, MMD_ALIAS_BASE, MMD_DATA_SIZE)
		|=> t_sel == TGT_DATA
			&& t_addr == $past(m_addr) - MMD_ALIAS_BASE + MMD_DATA_BASE;
	endproperty
	a_alias: assert property (p_alias) else $error("Alias translation wrong"); // RL5

	property p_bb_read;
		r_reg.st == ST_ACC && r_reg.bb && !r_reg.wr && t_ack
		|=> m_done && m_rdata[31:1] == 31'h0 && m_rdata[0] == $past(t_rdata[r_reg.bit_idx]);
	endproperty
	a_bb_read: assert property (p_bb_read) else $error("Bit-band read wrong"); // RL6

	property p_rbb_addr;
		take && m_is_cpu && in_rng(m_addr, MMD_RBB_BASE, MMD_ECREG_SIZE * 32'h20)
		|=> t_sel == TGT_REGS
			&& t_addr == MMD_REG_BASE + {5'h00, $past(m_addr[24:7]) , 9'h000} / 32'h80;
	endproperty
	a_rbb_addr: assert property (p_rbb_addr) else $error("Register bit-band address wrong"); // RL7

	property p_rbb_deny;
		take && in_rng(m_addr, MMD_RBB_BASE + 32'h0020_0000, 32'h00e0_0000)
		|=> m_fault && m_done ##1 m_ready;
	endproperty
	a_rbb_deny: assert property (p_rbb_deny) else $error("Bit-band to other registers"); // RL8

	property p_rmw;
		r_reg.st == ST_ACC && r_reg.bb && r_reg.wr && t_ack
		|=> !t_req ##1 t_req && t_write && $stable(t_addr);
	endproperty
	a_rmw: assert property (p_rmw) else $error("Bit-band write not read-modify-write"); // RL9

	property p_bb_master;
		take && !m_is_cpu && (in_rng(m_addr, MMD_SBB_BASE, MMD_SBB_SIZE)
			|| in_rng(m_addr, MMD_RBB_BASE, MMD_RBB_SIZE))
		|=> m_fault && m_done && !t_req;
	endproperty
	a_bb_master: assert property (p_bb_master) else $error("Non-processor bit-band"); // RL11

	property p_sbb_base;
		take && m_is_cpu && m_addr == MMD_SBB_BASE + 32'h0000_0084
		|=> t_addr == MMD_DATA_BASE + 32'h4 && r_reg.bit_idx == 5'h01;
	endproperty
	a_sbb_base: assert property (p_sbb_base) else $error("SRAM bit-band base wrong"); // RL12

	property p_crypto;
		take && in_rng(m_addr, MMD_CRYPTO_BASE, MMD_CRYPTO_SIZE)
		|=> t_sel == TGT_CRYPTO && t_req;
	endproperty
	a_crypto: assert property (p_crypto) else $error("Crypto window not decoded"); // RL13

	c_rom_fetch: cover property (take && m_fetch && m_addr == MMD_ROM_BASE ##[1:20] m_done);
	c_rmw: cover property (r_reg.st == ST_WB && t_ack);
	c_fault: cover property (m_done && m_fault);
	c_alias: cover property (take && in_rng(m_addr, MMD_ALIAS_BASE, MMD_DATA_SIZE));

endmodule : mmd_decoder

// ### mmd_target_model.sv
// Target memory model behind the decoder's translated port.
// Assumes one request at a time; lat sets the answer delay in cycles.
`timescale 1ns/1ps
module mmd_target_model
	import mmd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Target port
	input wire logic t_req,
	input wire logic [31:0] t_addr,
	input wire logic t_write,
	input wire logic [31:0] t_wdata,
	output logic t_ack,
	output logic [31:0] t_rdata,
	// Answer delay
	input wire logic [3:0] lat
);
	logic [31:0] mem [logic [31:0]];
	logic [3:0] cnt;

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			t_ack <= 1'b0;
			t_rdata <= 32'h0;
			cnt <= 4'h0;
		end
		else if (t_ack || !t_req)
		begin
			// Stale data is scrambled so nobody can lean on it
			t_ack <= 1'b0;
			t_rdata <= ~t_rdata;
			cnt <= 4'h0;
		end
		else if (cnt < lat)
			cnt <= cnt + 4'h1;
		else
		begin
			// Unwritten words read a fixed function of their address
			t_ack <= 1'b1;
			t_rdata <= mem.exists(t_addr) ? mem[t_addr] : t_addr ^ 32'h5a5a_5a5a;
			if (t_write)
				mem[t_addr] = t_wdata;
		end
	end
endmodule : mmd_target_model

// ### test_memory_map_decoder.sv
// Self-checking bench for mmd_decoder; the bench is the bus master.
// Assumes mmd_target_model answers the translated port.
`timescale 1ns/1ps
module test_memory_map_decoder;
	import mmd_pkg::*;
	typedef struct {logic [31:0] a; logic w; logic cpu; logic f; mmd_tgt_t sel;} mmd_row_t;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic m_req = 1'b0;
	logic m_write = 1'b0;
	logic m_is_cpu = 1'b1;
	logic m_fetch = 1'b0;
	logic [31:0] m_addr = 32'h0;
	logic [31:0] m_wdata = 32'h0;
	logic [3:0] lat = 4'h0;
	logic m_ready, m_done, m_fault, t_req, t_write, t_fetch, t_ack, flt, s_fetch;
	logic [31:0] m_rdata, t_addr, t_wdata, t_rdata, rd, s_addr, ta;
	mmd_tgt_t t_sel, s_sel;
	int err_count = 0;
	int n_tests = 0;
	int cycles = 0;
	int n_req = 0;
	int n0;
	mmd_row_t rows [14] = '{
		'{32'h0000_fffc, 0, 1, 0, TGT_ROM}, '{32'h0000_0010, 1, 1, 1, TGT_NONE},
		'{32'h0001_0000, 0, 1, 1, TGT_NONE}, '{32'h000b_0000, 0, 1, 0, TGT_CODE},
		'{32'h0011_7ffc, 1, 0, 0, TGT_CODE}, '{32'h0012_7ffc, 0, 0, 0, TGT_DATA},
		'{32'h0012_8000, 0, 1, 1, TGT_NONE}, '{32'h2000_fffc, 0, 1, 0, TGT_DATA},
		'{32'h400f_fffc, 0, 0, 0, TGT_REGS}, '{32'h4010_3ffc, 1, 0, 0, TGT_CRYPTO},
		'{32'h4010_4000, 0, 1, 1, TGT_NONE}, '{32'h2200_0000, 0, 0, 1, TGT_NONE},
		'{32'h43e0_0000, 0, 1, 1, TGT_NONE}, '{32'h4220_0000, 0, 1, 1, TGT_NONE}};

	mmd_decoder uut (.clk, .reset_n, .m_req, .m_addr, .m_write, .m_wdata, .m_is_cpu,
		.m_fetch, .m_ready, .m_done, .m_fault, .m_rdata, .t_req, .t_sel, .t_addr,
		.t_write, .t_wdata, .t_fetch, .t_ack, .t_rdata);
	mmd_target_model tgt (.clk, .reset_n, .t_req, .t_addr, .t_write, .t_wdata, .t_ack,
		.t_rdata, .lat);

	always #10 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (t_req && t_ack)
		begin
			s_sel <= t_sel;
			s_addr <= t_addr;
			s_fetch <= t_fetch;
			n_req <= n_req + 1;
		end
		if (cycles == 20000)
		begin
			err_count++;
			print_verdict();
		end
	end

	function automatic logic [31:0] dflt(logic [31:0] a);
		return a ^ 32'h5a5a_5a5a;
	endfunction : dflt

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic access(logic [31:0] a, logic w, logic [31:0] d, logic cpu, logic fe);
		int k;
		@(negedge clk);
		n0 = n_req;
		m_req = 1'b1;
		m_addr = a;
		m_write = w;
		m_wdata = d;
		m_is_cpu = cpu;
		m_fetch = fe;
		// Ready is read away from the edge, so the taking edge is known
		while (m_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		@(negedge clk);
		m_req = 1'b0;
		for (k = 0; k < 40 && m_done !== 1'b1; k++)
			@(negedge clk);
		check("done", 32'(m_done), 32'h1);
		rd = m_rdata;
		flt = m_fault;
	endtask : access

	task automatic print_verdict();
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// ***************************************
	// Main sequence
	// ***************************************
	initial
	begin
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		foreach (rows[i])
		begin
			access(rows[i].a, rows[i].w, ~rows[i].a, rows[i].cpu, 1'b0);
			ta = (rows[i].a[31:24] == 8'h20) ? rows[i].a - MMD_ALIAS_BASE + MMD_DATA_BASE
				: rows[i].a;
			check("fault", 32'(flt), 32'(rows[i].f));
			check("rdata", rd, rows[i].f ? 32'h0 : dflt(ta));
			if (rows[i].f)
				check("no_req", 32'(n_req - n0), 32'h0);
			else
			begin
				check("sel", 32'(s_sel), 32'(rows[i].sel));
				check("taddr", s_addr, ta);
			end
		end
		// Second reset in mid-run, then a boot fetch
		@(negedge clk);
		reset_n = 1'b0;
		@(negedge clk);
		check("rst_ready", 32'(m_ready), 32'h1);
		check("rst_treq", 32'(t_req), 32'h0);
		reset_n = 1'b1;
		access(32'h0, 1'b0, 32'h0, 1'b1, 1'b1);
		check("boot_sel", 32'(s_sel), 32'(TGT_ROM));
		check("boot_fetch", 32'(s_fetch), 32'h1);
		check("boot_data", rd, dflt(32'h0));
		access(32'h2000_0040, 1'b1, 32'hcafe_0123, 1'b1, 1'b0);
		access(32'h0011_8040, 1'b0, 32'h0, 1'b1, 1'b0);
		check("alias", rd, 32'hcafe_0123);
		access(32'h2200_2000, 1'b0, 32'h0, 1'b1, 1'b0);
		check("sbb_rd0", rd, 32'h0);
		access(32'h2200_2014, 1'b1, 32'h1, 1'b1, 1'b0);
		check("sbb_rmw", 32'(n_req - n0), 32'h2);
		access(32'h2200_2014, 1'b0, 32'h0, 1'b1, 1'b0);
		check("sbb_rd1", rd, 32'h1);
		access(32'h0011_8100, 1'b0, 32'h0, 1'b1, 1'b0);
		check("sbb_word", rd, dflt(32'h0011_8100) | 32'h20);
		access(32'h2200_0084, 1'b0, 32'h0, 1'b1, 1'b0);
		check("sbb_bit1", rd, (dflt(32'h0011_8004) >> 1) & 32'h1);
		check("sbb_addr", s_addr, 32'h0011_8004);
		// target has no read side effects
		access(32'h4200_020c, 1'b1, 32'h0, 1'b1, 1'b0);
		access(32'h4000_0010, 1'b0, 32'h0, 1'b1, 1'b0);
		check("rbb_clr", rd, dflt(32'h4000_0010) & ~32'h8);
		access(32'h4300_0084, 1'b0, 32'h0, 1'b1, 1'b0);
		check("rbb_rd", rd, 32'(dflt(32'h4008_0004) >> 1) & 32'h1);
		check("rbb_addr", s_addr, 32'h4008_0004);
		lat = 4'h5;
		access(32'h4010_0000, 1'b0, 32'h0, 1'b1, 1'b0);
		check("crypto", 32'(s_sel), 32'(TGT_CRYPTO));
		access(32'h000c_0000, 1'b0, 32'h0, 1'b1, 1'b1);
		check("slow_fetch", rd, dflt(32'h000c_0000));
		print_verdict();
	end
endmodule : test_memory_map_decoder
